// ==== hw/aotc_pkg.sv ====
package aotc_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_OFFSET_TRIM = 4'h0;
  localparam logic [3:0] ADDR_GAIN_LOW = 4'h1;
  localparam logic [3:0] ADDR_GAIN_HIGH = 4'h2;
  localparam logic [3:0] ADDR_AMP_CTRL = 4'h3;
  localparam logic [3:0] ADDR_SEQ_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SEQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_CROSS_CODES = 4'h6;
  // field positions
  localparam int MODE_BIT = 7;
  localparam int REF_BIT = 6;
  localparam int OPEN_BIT = 6;
  localparam int STATUS_BIT = 5;
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int FAIL_BIT = 2;
  // reset values and trim sweep limits
  localparam logic [5:0] TRIM_RESET = 6'h20;
  localparam logic [5:0] TRIM_MIN = 6'h00;
  localparam logic [5:0] TRIM_MAX = 6'h3f;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // settling time after each trim write, ns, and cycles at 20 MHz
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES_INT = (SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CYCLES = 8'(SETTLE_CYCLES_INT);
  // register bus request carrier
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } aotc_bus_req_t;
  // amplifier control carrier
  typedef struct packed {
    logic enable;
    logic cal_mode_select;
    logic cal_reference_select;
    logic [5:0] offset_trim_code;
    logic [8:0] feedback_code;
  } aotc_amp_ctrl_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_UP_SETTLE = 3'b001,
    SEQ_UP_STEP = 3'b010,
    SEQ_DN_SETTLE = 3'b011,
    SEQ_DN_STEP = 3'b100,
    SEQ_FINISH = 3'b101
  } aotc_seq_state_t;
endpackage : aotc_pkg

// ==== hw/aotc_sync.sv ====
`timescale 1ns/100ps
// two-flop synchroniser for the comparator output
module aotc_sync (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  // first stage feeds only the second
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : aotc_sync

// ==== hw/aotc_top.sv ====
`timescale 1ns/100ps
// What this block does
// (R1) bit 7 selects normal or calibration mode
// (R2) bit 6 selects calibration reference input pin
// (R3) six-bit trim code, resets to 100000
// (R4) nine-bit feedback code split across registers
// (R5) gain registers reset zero, unused bits zero
// (R6) software enables amplifier before calibrating
// (R7) calibration mode set first, matched reference
// (R8) upward sweep from 000000 finds lower crossing
// (R9) downward sweep from 111111 finds upper crossing
// (R10) finish with truncated mean of crossings
// (R11) status bit follows output in calibration
// (R12) wait settling time before sampling status
module aotc_top (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire aotc_pkg::aotc_bus_req_t i_bus,
  input wire logic i_amp_output,
  output logic [7:0] o_rdata,
  output aotc_pkg::aotc_amp_ctrl_t o_amp
);
  import aotc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // registers
  logic cal_mode_select;
  logic cal_reference_select;
  logic [5:0] offset_trim_code;
  logic [7:0] feedback_code_low;
  logic feedback_code_msb;
  logic amp_enable;
  logic amp_sync;
  logic amp_output_status;
  aotc_seq_state_t seq_state;
  logic [7:0] settle_count;
  logic first_sample;
  logic last_status;
  logic [5:0] lower_crossing_code;
  logic [5:0] upper_crossing_code;
  logic seq_done;
  logic seq_fail;
  logic seq_start;
  logic [5:0] seq_trim;
  logic seq_trim_write;

  // comparator pin arrives from the analog domain
  aotc_sync u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(i_amp_output),
    .o_sync(amp_sync)
  );

  function automatic logic is_write(input aotc_bus_req_t req, input logic [3:0] addr);
    is_write = req.write && (req.addr == addr);
  endfunction : is_write

  // truncated midpoint of two six-bit codes
  function automatic logic [5:0] midpoint(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    midpoint = sum[6:1];
  endfunction : midpoint

  //////////////////////////////////////////////////////////////////////
  // status bit: forced low outside calibration mode
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      amp_output_status <= 1'b0;
    end else begin
      amp_output_status <= cal_mode_select & amp_sync; // R11
    end
  end

  assign seq_start = is_write(i_bus, ADDR_SEQ_CTRL) && i_bus.wdata[START_BIT]
                     && (seq_state == SEQ_IDLE);

  //////////////////////////////////////////////////////////////////////
  // mode and reference bits; sequencer forces calibration mode on start
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cal_mode_select <= 1'b0;
      cal_reference_select <= 1'b0;
    end else if (is_write(i_bus, ADDR_OFFSET_TRIM)) begin
      cal_mode_select <= i_bus.wdata[MODE_BIT]; // R1
      cal_reference_select <= i_bus.wdata[REF_BIT]; // R2
    end else if (seq_start) begin
      cal_mode_select <= 1'b1; // R7
    end
  end

  // trim code: software write, else sequencer
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      offset_trim_code <= TRIM_RESET; // R3
    end else if (is_write(i_bus, ADDR_OFFSET_TRIM)) begin
      offset_trim_code <= i_bus.wdata[5:0]; // R3
    end else if (seq_trim_write) begin
      offset_trim_code <= seq_trim;
    end
  end

  // feedback resistance code, both halves reset to zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      feedback_code_low <= ZERO_BYTE; // R5
      feedback_code_msb <= 1'b0; // R5
    end else begin
      if (is_write(i_bus, ADDR_GAIN_LOW)) begin
        feedback_code_low <= i_bus.wdata; // R4
      end
      if (is_write(i_bus, ADDR_GAIN_HIGH)) begin
        feedback_code_msb <= i_bus.wdata[0]; // R4
      end
    end
  end

  // amplifier enable, needed before calibration
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      amp_enable <= 1'b0;
    end else if (is_write(i_bus, ADDR_AMP_CTRL)) begin
      amp_enable <= i_bus.wdata[OPEN_BIT]; // R6
    end
  end

  //////////////////////////////////////////////////////////////////////
  // hardware sweep sequencer; software writes to the trim register win
  always_comb begin
    seq_trim = offset_trim_code;
    seq_trim_write = 1'b0;
    case (seq_state)
      SEQ_IDLE: begin
        if (seq_start) begin
          seq_trim = TRIM_MIN; // R8
          seq_trim_write = 1'b1;
        end
      end
      SEQ_UP_STEP: begin
        if (!first_sample && amp_output_status != last_status) begin
          seq_trim = TRIM_MAX; // R9
          seq_trim_write = 1'b1;
        end else if (offset_trim_code != TRIM_MAX) begin
          seq_trim = offset_trim_code + 6'h01; // R8
          seq_trim_write = 1'b1;
        end
      end
      SEQ_DN_STEP: begin
        if (!first_sample && amp_output_status != last_status) begin
          seq_trim = midpoint(lower_crossing_code, offset_trim_code); // R10
          seq_trim_write = 1'b1;
        end else if (offset_trim_code != TRIM_MIN) begin
          seq_trim = offset_trim_code - 6'h01; // R9
          seq_trim_write = 1'b1;
        end
      end
      default: begin
        seq_trim = offset_trim_code;
      end
    endcase
  end

  // sequencer state; a sweep that never crosses ends with fail
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seq_state <= SEQ_IDLE;
      settle_count <= ZERO_BYTE;
      first_sample <= 1'b0;
      last_status <= 1'b0;
      lower_crossing_code <= TRIM_MIN;
      upper_crossing_code <= TRIM_MIN;
      seq_done <= 1'b0;
      seq_fail <= 1'b0;
    end else begin
      case (seq_state)
        SEQ_IDLE: begin
          if (seq_start) begin
            seq_state <= SEQ_UP_SETTLE;
            settle_count <= SETTLE_CYCLES; // R12
            first_sample <= 1'b1;
            seq_done <= 1'b0;
            seq_fail <= 1'b0;
          end
        end
        SEQ_UP_SETTLE, SEQ_DN_SETTLE: begin
          if (settle_count == ZERO_BYTE) begin
            seq_state <= (seq_state == SEQ_UP_SETTLE) ? SEQ_UP_STEP : SEQ_DN_STEP; // R12
          end else begin
            settle_count <= settle_count - 8'h01;
          end
        end
        SEQ_UP_STEP: begin
          last_status <= amp_output_status;
          first_sample <= 1'b0;
          settle_count <= SETTLE_CYCLES;
          if (!first_sample && amp_output_status != last_status) begin
            lower_crossing_code <= offset_trim_code; // R8
            first_sample <= 1'b1;
            seq_state <= SEQ_DN_SETTLE;
          end else if (offset_trim_code == TRIM_MAX) begin
            seq_fail <= 1'b1;
            seq_state <= SEQ_IDLE;
          end else begin
            seq_state <= SEQ_UP_SETTLE;
          end
        end
        SEQ_DN_STEP: begin
          last_status <= amp_output_status;
          first_sample <= 1'b0;
          settle_count <= SETTLE_CYCLES;
          if (!first_sample && amp_output_status != last_status) begin
            upper_crossing_code <= offset_trim_code; // R9
            seq_state <= SEQ_FINISH;
          end else if (offset_trim_code == TRIM_MIN) begin
            seq_fail <= 1'b1;
            seq_state <= SEQ_IDLE;
          end else begin
            seq_state <= SEQ_DN_SETTLE;
          end
        end
        SEQ_FINISH: begin
          seq_done <= 1'b1;
          seq_state <= SEQ_IDLE;
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= ZERO_BYTE;
    end else if (i_bus.read) begin
      case (i_bus.addr)
        ADDR_OFFSET_TRIM: o_rdata <= {cal_mode_select, cal_reference_select, offset_trim_code};
        ADDR_GAIN_LOW: o_rdata <= feedback_code_low;
        ADDR_GAIN_HIGH: o_rdata <= {7'h00, feedback_code_msb}; // R5
        ADDR_AMP_CTRL: o_rdata <= {1'b0, amp_enable, amp_output_status, 5'h00}; // R11
        ADDR_SEQ_STATUS: o_rdata <= {5'h00, seq_fail, seq_done, seq_state != SEQ_IDLE};
        ADDR_CROSS_CODES: o_rdata <= {2'h0, midpoint(lower_crossing_code, upper_crossing_code)};
        default: o_rdata <= ZERO_BYTE;
      endcase
    end else begin
      o_rdata <= ZERO_BYTE;
    end
  end

  // analog controls straight from flops
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_amp <= '0;
    end else begin
      o_amp.enable <= amp_enable;
      o_amp.cal_mode_select <= cal_mode_select; // R1
      o_amp.cal_reference_select <= cal_reference_select; // R2
      o_amp.offset_trim_code <= offset_trim_code; // R3
      o_amp.feedback_code <= {feedback_code_msb, feedback_code_low}; // R4
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence trim_write_s;
    is_write(i_bus, ADDR_OFFSET_TRIM);
  endsequence

  mode_follow_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R1
    trim_write_s |=> cal_mode_select == $past(i_bus.wdata[MODE_BIT]))
    else $error("mode bit did not take written value");
  ref_follow_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R2
    trim_write_s |=> cal_reference_select == $past(i_bus.wdata[REF_BIT]))
    else $error("reference bit did not take written value");
  trim_drive_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R3
    trim_write_s |=> ##1 o_amp.offset_trim_code == $past(i_bus.wdata[5:0], 2))
    else $error("trim code not applied to amplifier");
  gain_drive_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R4
    is_write(i_bus, ADDR_GAIN_LOW) |=> ##1 o_amp.feedback_code[7:0] == $past(i_bus.wdata, 2))
    else $error("feedback code low not applied");
  gain_high_zero_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R5
    (i_bus.read && i_bus.addr == ADDR_GAIN_HIGH) |=> o_rdata[7:1] == 7'h00)
    else $error("unused gain bits read nonzero");
  status_normal_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R11
    !$past(cal_mode_select) |-> !amp_output_status)
    else $error("status bit set in normal mode");
  sweep_start_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R8
    seq_start && !is_write(i_bus, ADDR_OFFSET_TRIM) |=>
      offset_trim_code == TRIM_MIN && cal_mode_select)
    else $error("sweep did not begin at zero in calibration mode");
  settle_wait_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R12
    seq_state == SEQ_IDLE ##1 seq_state == SEQ_UP_SETTLE |-> (seq_state != SEQ_UP_STEP) [*8])
    else $error("status sampled before settling");
  finish_mid_a: assert property (@(posedge i_clock) disable iff (!i_arst_n) // R10
    seq_state == SEQ_FINISH && !$past(is_write(i_bus, ADDR_OFFSET_TRIM)) |->
      offset_trim_code == midpoint(lower_crossing_code, upper_crossing_code))
    else $error("final trim is not the crossing midpoint");
endmodule : aotc_top

// ==== testbench/tb_aotc_top.sv ====
`timescale 1ns/100ps
module tb_aotc_top;
  import aotc_pkg::*;
  logic i_clock;
  logic i_arst_n;
  aotc_bus_req_t i_bus;
  logic i_amp_output;
  logic [7:0] o_rdata;
  aotc_amp_ctrl_t o_amp;
  int num_errors;
  int total_checks;
  logic [31:0] lfsr_q;
  logic [6:0] thresh;
  logic [7:0] sh0;
  logic [7:0] sh1;
  logic sh2;

  aotc_top dut_u (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_bus(i_bus),
    .i_amp_output(i_amp_output),
    .o_rdata(o_rdata),
    .o_amp(o_amp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a comparator that trips once the trim reaches the threshold
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // threshold 7'h40 never trips, 0 always trips; models a clean crossing
  always @(posedge i_clock) begin
    i_amp_output <= ({1'b0, o_amp.offset_trim_code} >= thresh);
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] rand8();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rand8
  // truncated mean of the two crossings
  function automatic logic [5:0] mid_of(input logic [5:0] lo, input logic [5:0] hi);
    logic [6:0] s;
    s = {1'b0, lo} + {1'b0, hi};
    return s[6:1];
  endfunction : mid_of
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge i_clock);
    i_bus <= '0;
  endtask : wr
  // data stands only in the cycle after the taken edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge i_clock);
    i_bus <= '0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // one hardware calibration run, polled until the sequencer goes idle
  task automatic run_cal(input logic [6:0] th, input logic ref_sel, input logic fail);
    logic [7:0] v;
    logic [5:0] m;
    int i;
    thresh = th;
    wr(ADDR_AMP_CTRL, 8'h40);
    wr(ADDR_OFFSET_TRIM, {1'b1, ref_sel, 6'h20});
    wr(ADDR_SEQ_CTRL, 8'h01);
    rd(ADDR_SEQ_STATUS, v);
    check("seq busy", {15'h0000, v[0]}, 16'h0001);
    // a second start while busy must be ignored, results stay as expected
    wr(ADDR_SEQ_CTRL, 8'h01);
    for (i = 0; i < 3000 && v[0] !== 1'b0; i++) begin
      rd(ADDR_SEQ_STATUS, v);
    end
    check("seq status", {8'h00, v}, fail ? 16'h0004 : 16'h0002);
    if (!fail) begin
      m = mid_of(th[5:0], th[5:0] - 6'h01);
      rd(ADDR_CROSS_CODES, v);
      check("cross mid", {8'h00, v}, {10'h000, m});
      rd(ADDR_OFFSET_TRIM, v);
      check("trim final", {8'h00, v}, {8'h00, 1'b1, ref_sel, m});
      check("amp trim", {10'h000, o_amp.offset_trim_code}, {10'h000, m});
    end
  endtask : run_cal

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #(50 * 40000);
    num_errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] v;
    logic [3:0] a;
    logic [7:0] d;
    int k;
    i_arst_n = 1'b0;
    i_bus = '0;
    thresh = 7'h40;
    num_errors = 0;
    total_checks = 0;
    lfsr_q = 32'h0001_3676;
    repeat (16) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    check("amp trim rst", {10'h000, o_amp.offset_trim_code}, 16'h0020);
    check("amp fb rst", {7'h00, o_amp.feedback_code}, 16'h0000);
    rd(ADDR_OFFSET_TRIM, v);
    check("trim rst", {8'h00, v}, 16'h0020);
    rd(ADDR_GAIN_LOW, v);
    check("gain low rst", {8'h00, v}, 16'h0000);
    rd(ADDR_GAIN_HIGH, v);
    check("gain high rst", {8'h00, v}, 16'h0000);
    rd(ADDR_AMP_CTRL, v);
    check("amp ctrl rst", {8'h00, v}, 16'h0000);
    sh0 = 8'h20;
    sh1 = 8'h00;
    sh2 = 1'b0;
    // random register traffic with a shadow copy, plus unmapped places
    for (k = 0; k < 24; k++) begin
      d = rand8();
      a = (k % 8 == 7) ? 4'hf : 4'(rand8() % 8'h03);
      wr(a, d);
      if (a == ADDR_OFFSET_TRIM) sh0 = d;
      if (a == ADDR_GAIN_LOW) sh1 = d;
      if (a == ADDR_GAIN_HIGH) sh2 = d[0];
      rd(a, v);
      if (a == 4'hf) check("unmapped", {8'h00, v}, 16'h0000);
      if (a == ADDR_OFFSET_TRIM) check("trim rb", {8'h00, v}, {8'h00, sh0});
      if (a == ADDR_GAIN_LOW) check("gain low rb", {8'h00, v}, {8'h00, sh1});
      if (a == ADDR_GAIN_HIGH) check("gain high rb", {8'h00, v}, {15'h0000, sh2});
      check("amp mode", {15'h0000, o_amp.cal_mode_select}, {15'h0000, sh0[7]});
      check("amp ref", {15'h0000, o_amp.cal_reference_select}, {15'h0000, sh0[6]});
      check("amp trim", {10'h000, o_amp.offset_trim_code}, {10'h000, sh0[5:0]});
      check("amp fb", {7'h00, o_amp.feedback_code}, {7'h00, sh2, sh1});
    end
    // status bit: zero in normal mode, follows the output in calibration
    thresh = 7'h00;
    wr(ADDR_OFFSET_TRIM, 8'h05);
    wr(ADDR_AMP_CTRL, 8'h40);
    repeat (6) @(posedge i_clock);
    rd(ADDR_AMP_CTRL, v);
    check("status normal", {8'h00, v}, 16'h0040);
    check("amp enable", {15'h0000, o_amp.enable}, 16'h0001);
    wr(ADDR_OFFSET_TRIM, 8'h85);
    repeat (6) @(posedge i_clock);
    rd(ADDR_AMP_CTRL, v);
    check("status cal hi", {8'h00, v}, 16'h0060);
    thresh = 7'h40;
    repeat (6) @(posedge i_clock);
    rd(ADDR_AMP_CTRL, v);
    check("status cal lo", {8'h00, v}, 16'h0040);
    // sequencer: no crossing, both ends of range, then a random threshold
    run_cal(7'h00, 1'b0, 1'b1);
    run_cal(7'h01, 1'b1, 1'b0);
    run_cal(7'h3f, 1'b0, 1'b0);
    d = rand8();
    run_cal({1'b0, (d[5:0] == 6'h00) ? 6'h11 : d[5:0]}, d[7], 1'b0);
    test_done();
  end
endmodule : tb_aotc_top
